// *** bench/tb.sv ***
// Purpose: Bench for the watch and interval timer.
// Assumes: Oscillators have a period of four clocks.
// Notes:   Expected APB results wait in a queue.
`timescale 1ns/100ps
`define CK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import wit_pkg::*;
   localparam logic [31:0] A = WATCH_MODE_CTRL_ADDR;
   logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic        main_osc_clock = 0, sub_clock = 0, pready, pslverr, watch_irq, interval_irq;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic [33:0] expq[$], ev;
   int          miscompares = 0, num_checks = 0, seed = 73, cyc = 0, n;
   wit_watch_interval_timer dut_u (.*);
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      sub_clock <= cyc[1];
      main_osc_clock <= cyc[1] ^ cyc[0];
   end
   always @(posedge pclk) begin
      if (presetn && ce && pready) begin
         ev = expq.pop_front();
         `CK("pslverr", ev[32], pslverr)
         if (ev[33]) `CK("prdata", ev[31:0], prdata)
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic apb(input logic wr, input logic [31:0] a, d, input logic [33:0] e);
      int k = 0;
      @(posedge pclk);
      expq.push_back(e);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (k >= 20) begin miscompares++; complete_run(); end
      {psel, penable} <= 2'h0;
   endtask : apb
   task automatic pulse(input logic w);
      n = 0;
      do begin @(posedge pclk); n++; end
      while ((w ? watch_irq : interval_irq) !== 1'b1 && n < 70000);
      if (n >= 70000) begin miscompares++; complete_run(); end
   endtask : pulse
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, A, 0, {2'h2, ZERO_WORD});
      apb(1, A, 32'h0000008d, 0);
      apb(0, A, 0, {2'h2, 32'h00000081});
      apb(1, A + 4, $random(seed), {2'h1, ZERO_WORD});
      apb(0, A + 4, 0, {2'h3, ZERO_WORD});
      ce <= 1'b0;
      repeat (1 + ($random(seed) & 3)) @(posedge pclk);
      ce <= 1'b1;
      $display("register test done");
      for (int s = 0; s < 7; s++) begin
         apb(1, A, 32'h81 | (s << 4), 0);
         pulse(0);
         pulse(0);
         `CK("interval", 4 << (4 + (s > 5 ? 5 : s)), n)
      end
      apb(1, A, 32'h00000001, 0);
      pulse(0);
      pulse(0);
      `CK("main interval", 8192, n)
      $display("interval test done");
      apb(1, A, ZERO_WORD, 0);
      apb(1, A, 32'h00000083, 0);
      pulse(1);
      `CK("watch delay", 1'b1, n > 67570 && n < 67600)
      $display("watch test done");
      complete_run();
   end
endmodule : tb

// *** bench/wit_props.sv ***
// Purpose: Pin-level checks for the timer.
// Assumes: Mode writes arrive over APB.
// Notes:   Keeps a copy of the mode register.
`timescale 1ns/100ps
module wit_props
   import wit_pkg::*;
#(parameter int PRE_BITS = 9, parameter int CNT_BITS = 5) (
   input wire logic        pclk,         // Clock.
   input wire logic        presetn,      // Reset.
   input wire logic        ce,           // Enable.
   input wire logic        psel,         // Select.
   input wire logic        penable,      // Access.
   input wire logic        pwrite,       // Write.
   input wire logic [31:0] paddr,        // Address.
   input wire logic [31:0] pwdata,       // Data in.
   input wire logic [31:0] prdata,       // Data out.
   input wire logic        pready,       // Ready.
   input wire logic        pslverr,      // Error.
   input wire logic        watch_irq,    // Watch.
   input wire logic        interval_irq  // Interval.
);
   logic [7:0] mode_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mode_q <= WATCH_MODE_CTRL_RST;
      else if (ce && pready && pwrite && !pslverr) mode_q <= pwdata[7:0] & WATCH_MODE_CTRL_WMSK;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_rdy_late: assert property (psel && !penable && ce |=> pready)
      else $error("no ready");
   chk_err_addr: assert property (pready |-> pslverr == (paddr != WATCH_MODE_CTRL_ADDR))
      else $error("bad error flag");
   chk_read_val: assert property (pready && !pwrite |->
      prdata == (pslverr ? ZERO_WORD : {24'h000000, mode_q})) else $error("bad read");
   chk_off_quiet: assert property (!mode_q[0] && !$past(mode_q[0]) && !$past(mode_q[0], 2)
      |-> !watch_irq && !interval_irq) else $error("pulse while off");
   chk_watch_run: assert property (watch_irq |-> $past(mode_q[1:0], 2) == 2'h3)
      else $error("watch while stopped");
   chk_watch_tap: assert property (watch_irq |-> interval_irq)
      else $error("watch off tap");
   chk_itv_pulse: assert property (interval_irq && ce |=> !interval_irq)
      else $error("long interval pulse");
   chk_watch_pulse: assert property (watch_irq && ce |=> !watch_irq)
      else $error("long watch pulse");
   cover property (watch_irq);
   cover property (interval_irq && mode_q[7]);
   cover property (pready && pslverr);
endmodule : wit_props

bind wit_watch_interval_timer wit_props #(.PRE_BITS(PRE_BITS), .CNT_BITS(CNT_BITS)) props_u (.*);

// *** inc/wit_pkg.sv ***
// Purpose: Shared constants and types for the watch and interval timer.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Register index times four gives the byte address.
package wit_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [31:0] WATCH_MODE_CTRL_IDX  = 32'h0000ff4a;
   localparam logic [31:0] WATCH_MODE_CTRL_ADDR = WATCH_MODE_CTRL_IDX << 2;
   localparam logic [7:0]  WATCH_MODE_CTRL_RST  = 8'h00;
   localparam logic [7:0]  WATCH_MODE_CTRL_WMSK = 8'hf3;

   // ---------------------------------------------------------------
   // Field layout and timing figures
   // ---------------------------------------------------------------
   localparam int          MAIN_DIV_BITS   = 7;
   localparam int          PRESCALE_BITS   = 9;
   localparam int          WATCH_CNT_BITS  = 5;
   localparam int          TAP_BASE        = 4;
   localparam logic [2:0]  SEL_MAX_LEGAL   = 3'h5;
   localparam logic [31:0] ZERO_WORD       = 32'h00000000;

   typedef struct packed {
      logic       count_clock_sel;
      logic [2:0] interval_sel;
      logic [1:0] reserved;
      logic       watch_counter_run;
      logic       watch_op_enable;
   } wit_ctrl_type;

endpackage : wit_pkg

// *** rtl/wit_watch_interval_timer.sv ***
// Purpose: Watch timer and interval timer with an APB register slave.
// Assumes: main_osc_clock and sub_clock are levels synchronous to pclk,
//          each slower than half the pclk rate.
// Notes:   Zero-wait APB; pslverr on any address but the mode register.
//          Count-clock ticks are single pclk pulses taken from sampled levels, so each
//          oscillator level must stay stable for at least one pclk period.
//          Prohibited interval codes act as the longest tap rather than stopping.
//
// Overview of operation
// - Watch interrupt every 2^14 count-clock periods, 0.5 s at 32.768 kHz.
// - Watch counting begins when op-enable and counter-run are both one.
// - Writing both bits zero clears the 5-bit counter and halts counting.
// - Clearing counter-run alone clears and stops watch count; prescaler keeps running.
// - Interval interrupt repeats once per selected interval while enabled.
// - Bits 4 to 6 pick tap 2^4..2^9; codes 110 and 111 prohibited.
// - Counter waits one prescaler cycle after start, delaying first interrupt.
// - Bit 7 selects main clock divided by 2^7 or subsystem clock.
// - Op-enable low holds prescaler and counter cleared, no interrupts.
// - Reset loads the whole mode control register with zero.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module wit_watch_interval_timer
   import wit_pkg::*;
#(
   parameter int PRE_BITS = PRESCALE_BITS,
   parameter int CNT_BITS = WATCH_CNT_BITS
) (
   input  wire logic        pclk,            // System clock, 20 MHz.
   input  wire logic        presetn,         // Asynchronous reset, active low.
   input  wire logic        ce,              // Clock enable; low freezes all state.
   input  wire logic        psel,            // APB select.
   input  wire logic        penable,         // APB access phase.
   input  wire logic        pwrite,          // APB direction, high for write.
   input  wire logic [31:0] paddr,           // APB byte address.
   input  wire logic [31:0] pwdata,          // APB write data.
   output logic      [31:0] prdata,          // APB read data.
   output logic             pready,          // APB ready.
   output logic             pslverr,         // APB error for unmapped address.
   input  wire logic        main_osc_clock,  // Main oscillator level, sampled.
   input  wire logic        sub_clock,       // Subsystem oscillator level, sampled.
   output logic             watch_irq,       // Watch interrupt, one-cycle pulse.
   output logic             interval_irq     // Interval interrupt, one-cycle pulse.
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The prescaler width is fixed by the interval taps and the watch period.
   initial begin
      if (PRE_BITS != PRESCALE_BITS) begin
         $error("wit_watch_interval_timer: prescaler width must stay at its default");
      end
      if (CNT_BITS < 1 || CNT_BITS > 16) begin
         $error("wit_watch_interval_timer: watch counter width out of range");
      end
      if (TAP_BASE + int'(SEL_MAX_LEGAL) > PRE_BITS) begin
         $error("wit_watch_interval_timer: longest interval tap lies outside the prescaler");
      end
      if (MAIN_DIV_BITS < 1) begin
         $error("wit_watch_interval_timer: main clock divider needs at least one bit");
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   wit_ctrl_type ctrl_q;
   logic         hit;
   logic         setup;
   logic         wr_take;
   logic [31:0]  rd_word;

   assign hit     = (paddr == WATCH_MODE_CTRL_ADDR);
   assign setup   = psel && !penable;
   assign wr_take = psel && penable && pready && pwrite && hit;
   assign rd_word = {24'h000000, ctrl_q};

   // Every access is answered in the cycle after its setup, with no wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= setup;
      end
   end

   // A stray address is refused with an error and leaves the mode register alone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (ce) begin
         pslverr <= setup && !hit;
      end
   end

   // Read data is captured at setup and holds until the next setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= ZERO_WORD;
      end else if (ce && setup) begin
         prdata <= (hit && !pwrite) ? rd_word : ZERO_WORD;
      end
   end

   // Reserved bits are masked so that they always read back as zero.
   wit_ctrl_type ctrl_d;

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_take) begin
         ctrl_d = wit_ctrl_type'(pwdata[7:0] & WATCH_MODE_CTRL_WMSK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= wit_ctrl_type'(WATCH_MODE_CTRL_RST);
      end else if (ce) begin
         ctrl_q <= ctrl_d;
      end
   end

   // ---------------------------------------------------------------
   // Count clock selection
   // ---------------------------------------------------------------
   logic                     main_lvl_q;
   logic                     sub_lvl_q;
   logic [MAIN_DIV_BITS-1:0] main_div_q;
   logic                     main_rise;
   logic                     sub_rise;
   logic                     main_div_tick;
   logic                     fw_tick;

   assign main_rise     = main_osc_clock && !main_lvl_q;
   assign sub_rise      = sub_clock && !sub_lvl_q;
   assign main_div_tick = main_rise && (&main_div_q);
   assign fw_tick       = ctrl_q.count_clock_sel ? sub_rise : main_div_tick;

   // Each level is remembered for one cycle so that a rising edge lasts one pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_lvl_q <= 1'b0;
      end else if (ce) begin
         main_lvl_q <= main_osc_clock;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_lvl_q <= 1'b0;
      end else if (ce) begin
         sub_lvl_q <= sub_clock;
      end
   end

   // The main divider runs freely so that switching the source needs no restart.
   logic [MAIN_DIV_BITS-1:0] main_div_d;

   always_comb begin
      main_div_d = main_div_q;
      if (main_rise) begin
         main_div_d = main_div_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_div_q <= '0;
      end else if (ce) begin
         main_div_q <= main_div_d;
      end
   end

   // ---------------------------------------------------------------
   // Prescaler and interval tap
   // ---------------------------------------------------------------
   logic [PRE_BITS-1:0] pre_q;
   logic [PRE_BITS-1:0] tap_wrap;
   logic [2:0]          sel_eff;
   logic                pre_wrap;
   logic                op_on;
   logic                run_on;

   assign op_on    = ctrl_q.watch_op_enable;
   assign run_on   = op_on && ctrl_q.watch_counter_run;
   // Prohibited codes behave as the longest tap.
   assign sel_eff  = (ctrl_q.interval_sel > SEL_MAX_LEGAL) ?
                     SEL_MAX_LEGAL : ctrl_q.interval_sel;
   assign pre_wrap = fw_tick && (&pre_q);

   genvar gi;
   generate
      for (gi = 0; gi < PRE_BITS; gi = gi + 1) begin : g_tap
         // Bit gi copies prescaler bit gi below the chosen tap and is one at the tap and above it.
         assign tap_wrap[gi] = (gi < TAP_BASE + int'(sel_eff)) ? pre_q[gi] : 1'b1;
      end
   endgenerate

   // Only op-enable clears the prescaler; counter-run leaves it running.
   logic [PRE_BITS-1:0] pre_d;
   logic                interval_d;

   always_comb begin
      pre_d = pre_q;
      if (!op_on) begin
         pre_d = '0;
      end else if (fw_tick) begin
         pre_d = pre_q + 1'b1;
      end
   end

   assign interval_d = op_on && fw_tick && (&tap_wrap);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
      end else if (ce) begin
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interval_irq <= 1'b0;
      end else if (ce) begin
         interval_irq <= interval_d;
      end
   end

   // ---------------------------------------------------------------
   // Watch counter
   // ---------------------------------------------------------------
   logic [CNT_BITS-1:0] cnt_q;
   logic                armed_q;

   logic [CNT_BITS-1:0] cnt_d;
   logic                armed_d;
   logic                watch_d;

   // The first prescaler wrap after a start only arms the counter, which delays
   // the first watch interrupt by one prescaler period.
   always_comb begin
      armed_d = armed_q;
      if (!run_on) begin
         armed_d = 1'b0;
      end else if (pre_wrap) begin
         armed_d = 1'b1;
      end
   end

   // Stopping the count clears the counter so that a restart begins from zero.
   always_comb begin
      cnt_d = cnt_q;
      if (!run_on) begin
         cnt_d = '0;
      end else if (pre_wrap && armed_q) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   assign watch_d = run_on && armed_q && pre_wrap && (&cnt_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
      end else if (ce) begin
         armed_q <= armed_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt outputs
   // ---------------------------------------------------------------
   // The watch pulse is registered so that it leaves the block from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watch_irq <= 1'b0;
      end else if (ce) begin
         watch_irq <= watch_d;
      end
   end

endmodule : wit_watch_interval_timer
